/* File: inc/sfp_defines.svh */
// Purpose: opcodes, field positions and timing figures of the flash sequencer
// Assumes: included by bare name, after the package where types are needed
// Notes: times are maxima in microseconds; cycle counts derive in the core
`ifndef SFP_DEFINES_SVH
`define SFP_DEFINES_SVH
`define SFP_OPC_BUF1_WRITE 8'h84
`define SFP_OPC_BUF2_WRITE 8'h87
`define SFP_OPC_BUF1_PROG_ERASE 8'h83
`define SFP_OPC_BUF2_PROG_ERASE 8'h86
`define SFP_OPC_BUF1_PROG_ONLY 8'h88
`define SFP_OPC_BUF2_PROG_ONLY 8'h89
`define SFP_OPC_PAGE_ERASE 8'h81
`define SFP_OPC_BLOCK_ERASE 8'h50
`define SFP_OPC_BUF1_MM_PROG 8'h82
`define SFP_OPC_BUF2_MM_PROG 8'h85
`define SFP_OPC_BUF1_REWRITE 8'h58
`define SFP_OPC_BUF2_REWRITE 8'h59
`define SFP_OPC_BUF1_XFER 8'h53
`define SFP_OPC_BUF2_XFER 8'h55
`define SFP_OPC_BUF1_COMPARE 8'h60
`define SFP_OPC_BUF2_COMPARE 8'h61
`define SFP_OPC_STATUS 8'h57
`define SFP_OPC_LAST_BIT 6'h07
`define SFP_HDR_LAST_BIT 6'h1F
`define SFP_HDR_BITS 6'h20
`define SFP_PAGE_MSB 22
`define SFP_PAGE_LSB 10
`define SFP_BADDR_MSB 9
`define SFP_BLOCK_LSB 3
`define SFP_BUF_BYTES 528
`define SFP_ST_RESERVED 3'h0
`define SFP_CLK_PERIOD_NS 10
`define SFP_XFER_TIME_US 300
`define SFP_PAGE_ERASE_TIME_US 6000
`define SFP_PROG_ONLY_TIME_US 13000
`define SFP_ERASE_PROG_TIME_US 20000
`define SFP_BLOCK_ERASE_TIME_US 15000
`endif

/* File: inc/sfp_pkg.sv */
// Purpose: types shared by the flash sequencer files
// Assumes: nothing
// Notes: state codes are Gray along the rewrite path
package sfp_pkg;
	typedef enum logic [3:0] {
		OP_NONE, OP_XFER, OP_COMPARE, OP_PROG_ERASE, OP_PROG_ONLY,
		OP_PAGE_ERASE, OP_BLOCK_ERASE, OP_MM_PROG, OP_REWRITE,
		OP_BUF_WRITE, OP_STATUS
	} sfp_op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_XFER = 2'h1,
		ST_ERASE = 2'h3,
		ST_PROG = 2'h2
	} sfp_state_t;
endpackage

/* File: core/sfp_buf_mem.sv */
// Purpose: two-clock byte memory holding both data buffers
// Assumes: write and read clocks unrelated; caller keeps them off one word
// Notes: read data comes out of a register, one read clock after the address
`timescale 1ns/1ps
module sfp_buf_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 1056,
	parameter int AW = 11
) (
	input wire logic wclk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic rclk_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);
	logic [WIDTH-1:0] mem_reg [DEPTH];

	// Out of range addresses are dropped, not aliased
	always_ff @(posedge wclk_i) begin
		if (we_i && (32'(waddr_i) < DEPTH)) begin
			mem_reg[waddr_i] <= wdata_i;
		end
	end

	always_ff @(posedge rclk_i) begin
		rdata_o <= (32'(raddr_i) < DEPTH) ? mem_reg[raddr_i] : '0;
	end
endmodule // sfp_buf_mem

/* File: core/sfp_flash_seq.sv */
// Purpose: serial command decoder and self-timed program sequencer
// Assumes: serial clock is its own domain and stands still outside frames
// Notes: array contents live outside; this block times and steers them
`timescale 1ns/1ps
`include "sfp_defines.svh"
module sfp_flash_seq
	import sfp_pkg::*;
#(
	parameter int XFER_CYC = `SFP_XFER_TIME_US * 1000 / `SFP_CLK_PERIOD_NS,
	parameter int PE_CYC =
		`SFP_PAGE_ERASE_TIME_US * 1000 / `SFP_CLK_PERIOD_NS,
	parameter int P_CYC = `SFP_PROG_ONLY_TIME_US * 1000 / `SFP_CLK_PERIOD_NS,
	parameter int EP_CYC =
		`SFP_ERASE_PROG_TIME_US * 1000 / `SFP_CLK_PERIOD_NS,
	parameter int BE_CYC =
		`SFP_BLOCK_ERASE_TIME_US * 1000 / `SFP_CLK_PERIOD_NS,
	// Arbitrary value
	parameter logic [2:0] DENSITY_CODE = 3'h5,
	parameter int BUF_BYTES = `SFP_BUF_BYTES
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic sck_i,
	input wire logic cs_n_i,
	input wire logic si_i,
	output logic so_o,
	output logic so_oe_o,
	output logic rdy_busy_o,
	output logic rdy_busy_oe_o,
	input wire logic dev_rst_n_i,
	input wire logic array_mismatch_i,
	output logic array_erase_o,
	output logic array_block_o,
	output logic [12:0] array_page_o,
	output logic array_we_o,
	output logic [9:0] array_byte_o,
	output logic [7:0] array_data_o
);
	localparam int AW = 11;

	function automatic sfp_op_t decode_op(input logic [7:0] opc);
		sfp_op_t op;
		case (opc)
			`SFP_OPC_BUF1_WRITE, `SFP_OPC_BUF2_WRITE: op = OP_BUF_WRITE;
			`SFP_OPC_BUF1_PROG_ERASE, `SFP_OPC_BUF2_PROG_ERASE: op = OP_PROG_ERASE;
			`SFP_OPC_BUF1_PROG_ONLY, `SFP_OPC_BUF2_PROG_ONLY: op = OP_PROG_ONLY;
			`SFP_OPC_PAGE_ERASE: op = OP_PAGE_ERASE;
			`SFP_OPC_BLOCK_ERASE: op = OP_BLOCK_ERASE;
			`SFP_OPC_BUF1_MM_PROG, `SFP_OPC_BUF2_MM_PROG: op = OP_MM_PROG;
			`SFP_OPC_BUF1_REWRITE, `SFP_OPC_BUF2_REWRITE: op = OP_REWRITE;
			`SFP_OPC_BUF1_XFER, `SFP_OPC_BUF2_XFER: op = OP_XFER;
			`SFP_OPC_BUF1_COMPARE, `SFP_OPC_BUF2_COMPARE: op = OP_COMPARE;
			`SFP_OPC_STATUS: op = OP_STATUS;
			default: op = OP_NONE;
		endcase
		return op;
	endfunction

	function automatic logic second_buf(input logic [7:0] opc);
		return opc inside {`SFP_OPC_BUF2_WRITE, `SFP_OPC_BUF2_PROG_ERASE,
			`SFP_OPC_BUF2_PROG_ONLY, `SFP_OPC_BUF2_MM_PROG,
			`SFP_OPC_BUF2_REWRITE, `SFP_OPC_BUF2_XFER,
			`SFP_OPC_BUF2_COMPARE};
	endfunction

	// Serial side, rising edge: frame state dies with select high
	logic frame_rst_n;
	logic [5:0] hdr_cnt_reg, hdr_cnt_next;
	logic [2:0] bit_ph_reg, bit_ph_next;
	logic [31:0] sh_reg, sh_next;
	sfp_op_t frame_op_reg, frame_op_next;
	logic frame_buf_reg, frame_buf_next;
	// Command side survives the frame for the sequencer to pick up
	sfp_op_t cmd_op_reg, cmd_op_next;
	logic [12:0] page_reg, page_next;
	logic [9:0] baddr_reg, baddr_next;
	logic buf_sel_reg, buf_sel_next;
	logic launch_tog_reg, launch_tog_next;
	logic wr_en;
	logic [7:0] wr_data;
	logic [AW-1:0] wr_addr;
	logic comp_s1_reg, comp_s2_reg;
	// Serial side, falling edge
	logic so_en_reg, so_en_next;
	logic [2:0] so_idx_reg, so_idx_next;
	logic [7:0] so_byte_reg, so_byte_next;
	logic st_mode;
	// Core clock side
	logic cs_s1_reg, cs_s2_reg, cs_s3_reg;
	logic tog_s1_reg, tog_s2_reg;
	logic rst_s1_reg, rst_s2_reg;
	sfp_state_t state_reg, state_next;
	logic [31:0] tmr_reg, tmr_next;
	logic ack_reg, ack_next;
	sfp_op_t lop_reg, lop_next;
	logic [12:0] lpage_reg, lpage_next;
	logic lbuf_reg, lbuf_next;
	logic comp_reg, comp_next;
	logic stream_reg, stream_next;
	logic [9:0] rd_cnt_reg, rd_cnt_next;
	logic we_reg, we_next;
	logic [9:0] abyte_reg, abyte_next;
	logic erase_reg, erase_next;
	logic [AW-1:0] rd_addr;
	logic ready;

	assign frame_rst_n = nrst_i & ~cs_n_i;

	always_comb begin
		sh_next = {sh_reg[30:0], si_i};
		hdr_cnt_next = (hdr_cnt_reg == `SFP_HDR_BITS) ? hdr_cnt_reg
			: hdr_cnt_reg + 6'h01;
		bit_ph_next = bit_ph_reg + 3'h1;
		frame_op_next = frame_op_reg;
		frame_buf_next = frame_buf_reg;
		cmd_op_next = cmd_op_reg;
		page_next = page_reg;
		baddr_next = baddr_reg;
		buf_sel_next = buf_sel_reg;
		launch_tog_next = launch_tog_reg;
		wr_en = 1'b0;
		if (hdr_cnt_reg == `SFP_OPC_LAST_BIT) begin
			frame_op_next = decode_op(sh_next[7:0]);
			frame_buf_next = second_buf(sh_next[7:0]);
		end
		if (hdr_cnt_reg == `SFP_HDR_LAST_BIT) begin
			cmd_op_next = frame_op_reg;
			buf_sel_next = frame_buf_reg;
			page_next = sh_next[`SFP_PAGE_MSB:`SFP_PAGE_LSB];
			baddr_next = sh_next[`SFP_BADDR_MSB:0];
			if (frame_op_reg inside {OP_XFER, OP_COMPARE, OP_PROG_ERASE,
				OP_PROG_ONLY, OP_PAGE_ERASE, OP_BLOCK_ERASE, OP_MM_PROG,
				OP_REWRITE}) begin
				launch_tog_next = ~launch_tog_reg;
			end
		end
		// Data bytes after the 32 header bits, stored until select rises
		if (hdr_cnt_reg == `SFP_HDR_BITS && bit_ph_reg == 3'h7 &&
			(frame_op_reg == OP_BUF_WRITE || frame_op_reg == OP_MM_PROG)) begin
			wr_en = 1'b1;
			baddr_next = (baddr_reg >= 10'(BUF_BYTES - 1)) ? 10'h000
				: baddr_reg + 10'h001;
		end
	end

	assign wr_data = sh_next[7:0];
	assign wr_addr = {1'b0, baddr_reg} + (buf_sel_reg ? 11'(BUF_BYTES)
		: 11'h000);

	always_ff @(posedge sck_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			hdr_cnt_reg <= 6'h00;
			bit_ph_reg <= 3'h0;
			sh_reg <= 32'h0000_0000;
			frame_op_reg <= OP_NONE;
			frame_buf_reg <= 1'b0;
		end else begin
			hdr_cnt_reg <= hdr_cnt_next;
			bit_ph_reg <= bit_ph_next;
			sh_reg <= sh_next;
			frame_op_reg <= frame_op_next;
			frame_buf_reg <= frame_buf_next;
		end
	end

	always_ff @(posedge sck_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cmd_op_reg <= OP_NONE;
			page_reg <= 13'h0000;
			baddr_reg <= 10'h000;
			buf_sel_reg <= 1'b0;
			launch_tog_reg <= 1'b0;
			comp_s1_reg <= 1'b0;
			comp_s2_reg <= 1'b0;
		end else begin
			cmd_op_reg <= cmd_op_next;
			page_reg <= page_next;
			baddr_reg <= baddr_next;
			buf_sel_reg <= buf_sel_next;
			launch_tog_reg <= launch_tog_next;
			comp_s1_reg <= comp_reg;
			comp_s2_reg <= comp_s1_reg;
		end
	end

	// Output side: change on the falling edge, sampled by host on the rise
	assign st_mode = (frame_op_reg == OP_STATUS) &&
		(hdr_cnt_reg > `SFP_OPC_LAST_BIT);

	always_comb begin
		so_en_next = st_mode;
		so_idx_next = ~bit_ph_reg;
		so_byte_next = so_byte_reg;
		// Fresh snapshot at every byte boundary
		if (st_mode && bit_ph_reg == 3'h0) begin
			so_byte_next = {1'b0, comp_s2_reg, DENSITY_CODE,
				`SFP_ST_RESERVED};
		end
	end

	always_ff @(negedge sck_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			so_en_reg <= 1'b0;
			so_idx_reg <= 3'h7;
			so_byte_reg <= 8'h00;
		end else begin
			so_en_reg <= so_en_next;
			so_idx_reg <= so_idx_next;
			so_byte_reg <= so_byte_next;
		end
	end

	// Bit 7 bypasses the snapshot so a stopped clock still sees live ready
	assign so_o = (so_idx_reg == 3'h7) ? ready
		: so_byte_reg[so_idx_reg];
	assign so_oe_o = so_en_reg;

	sfp_buf_mem #(
		.WIDTH(8),
		.DEPTH(2 * BUF_BYTES),
		.AW(AW)
	) u_buf_mem (
		.wclk_i(sck_i),
		.we_i(wr_en),
		.waddr_i(wr_addr),
		.wdata_i(wr_data),
		.rclk_i(clk_i),
		.raddr_i(rd_addr),
		.rdata_o(array_data_o)
	);

	// Sequencer on the core clock
	assign ready = (state_reg == ST_IDLE);
	assign rd_addr = {1'b0, rd_cnt_reg} + (lbuf_reg ? 11'(BUF_BYTES)
		: 11'h000);

	always_comb begin
		state_next = state_reg;
		tmr_next = tmr_reg;
		ack_next = ack_reg;
		lop_next = lop_reg;
		lpage_next = lpage_reg;
		lbuf_next = lbuf_reg;
		comp_next = comp_reg;
		stream_next = stream_reg;
		rd_cnt_next = rd_cnt_reg;
		we_next = stream_reg;
		abyte_next = rd_cnt_reg;
		erase_next = 1'b0;
		if (stream_reg) begin
			rd_cnt_next = rd_cnt_reg + 10'h001;
			stream_next = (rd_cnt_reg != 10'(BUF_BYTES - 1));
		end
		if (!rst_s2_reg) begin
			state_next = ST_IDLE;
			tmr_next = 32'h0000_0000;
			stream_next = 1'b0;
			we_next = 1'b0;
			ack_next = tog_s2_reg;
		end else if (cs_s2_reg && !cs_s3_reg && tog_s2_reg != ack_reg) begin
			// Launch on select rise; a launch while busy is dropped
			ack_next = tog_s2_reg;
			if (state_reg == ST_IDLE) begin
				lop_next = cmd_op_reg;
				lpage_next = page_reg;
				lbuf_next = buf_sel_reg;
				case (cmd_op_reg)
					OP_XFER, OP_COMPARE, OP_REWRITE: begin
						state_next = ST_XFER;
						tmr_next = 32'(XFER_CYC);
					end
					OP_PROG_ONLY: begin
						state_next = ST_PROG;
						tmr_next = 32'(P_CYC);
						stream_next = 1'b1;
						rd_cnt_next = 10'h000;
					end
					OP_PAGE_ERASE: begin
						state_next = ST_ERASE;
						tmr_next = 32'(PE_CYC);
						erase_next = 1'b1;
					end
					OP_BLOCK_ERASE: begin
						state_next = ST_ERASE;
						tmr_next = 32'(BE_CYC);
						erase_next = 1'b1;
					end
					default: begin
						state_next = ST_ERASE;
						tmr_next = 32'(EP_CYC - P_CYC);
						erase_next = 1'b1;
					end
				endcase
			end
		end else if (state_reg != ST_IDLE) begin
			if (tmr_reg > 32'h0000_0001) begin
				tmr_next = tmr_reg - 32'h0000_0001;
			end else begin
				case (state_reg)
					ST_XFER: begin
						if (lop_reg == OP_REWRITE) begin
							state_next = ST_ERASE;
							tmr_next = 32'(EP_CYC - P_CYC - XFER_CYC);
							erase_next = 1'b1;
						end else begin
							state_next = ST_IDLE;
							if (lop_reg == OP_COMPARE) begin
								comp_next = array_mismatch_i;
							end
						end
					end
					ST_ERASE: begin
						if (lop_reg inside {OP_PAGE_ERASE, OP_BLOCK_ERASE}) begin
							state_next = ST_IDLE;
						end else begin
							state_next = ST_PROG;
							tmr_next = 32'(P_CYC);
							stream_next = 1'b1;
							rd_cnt_next = 10'h000;
						end
					end
					default: state_next = ST_IDLE;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cs_s1_reg <= 1'b1;
			cs_s2_reg <= 1'b1;
			cs_s3_reg <= 1'b1;
			tog_s1_reg <= 1'b0;
			tog_s2_reg <= 1'b0;
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
			state_reg <= ST_IDLE;
			tmr_reg <= 32'h0000_0000;
			ack_reg <= 1'b0;
			lop_reg <= OP_NONE;
			lpage_reg <= 13'h0000;
			lbuf_reg <= 1'b0;
			comp_reg <= 1'b0;
			stream_reg <= 1'b0;
			rd_cnt_reg <= 10'h000;
			we_reg <= 1'b0;
			abyte_reg <= 10'h000;
			erase_reg <= 1'b0;
		end else begin
			cs_s1_reg <= cs_n_i;
			cs_s2_reg <= cs_s1_reg;
			cs_s3_reg <= cs_s2_reg;
			tog_s1_reg <= launch_tog_reg;
			tog_s2_reg <= tog_s1_reg;
			rst_s1_reg <= dev_rst_n_i;
			rst_s2_reg <= rst_s1_reg;
			state_reg <= state_next;
			tmr_reg <= tmr_next;
			ack_reg <= ack_next;
			lop_reg <= lop_next;
			lpage_reg <= lpage_next;
			lbuf_reg <= lbuf_next;
			comp_reg <= comp_next;
			stream_reg <= stream_next;
			rd_cnt_reg <= rd_cnt_next;
			we_reg <= we_next;
			abyte_reg <= abyte_next;
			erase_reg <= erase_next;
		end
	end

	// Open drain: only ever pulls low
	assign rdy_busy_o = 1'b0;
	assign rdy_busy_oe_o = ~ready;
	assign array_erase_o = erase_reg;
	assign array_block_o = (lop_reg == OP_BLOCK_ERASE);
	assign array_page_o = (lop_reg == OP_BLOCK_ERASE)
		? {lpage_reg[12:`SFP_BLOCK_LSB], 3'h0} : lpage_reg;
	assign array_we_o = we_reg;
	assign array_byte_o = abyte_reg;
endmodule // sfp_flash_seq

/* File: test/sfp_flash_seq_asserts.sv */
// Purpose: port checks of the flash sequencer
// Assumes: bound to sfp_flash_seq; core clock domain only
// Notes: busy length bound uses the longest self-timed figure
`timescale 1ns/1ps
module sfp_flash_seq_asserts #(
	parameter int EP_CYC = 700
) (
	input wire logic clk_i,
	input wire logic nrst_i,
	input wire logic cs_n_i,
	input wire logic dev_rst_n_i,
	input wire logic so_oe_o,
	input wire logic rdy_busy_o,
	input wire logic rdy_busy_oe_o,
	input wire logic array_erase_o,
	input wire logic array_block_o,
	input wire logic [12:0] array_page_o,
	input wire logic array_we_o,
	input wire logic [9:0] array_byte_o
);
	int bcnt_reg;
	int bcnt_next;
	always_comb begin
		bcnt_next = rdy_busy_oe_o ? bcnt_reg + 1 : 0;
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			bcnt_reg <= 0;
		end else begin
			bcnt_reg <= bcnt_next;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	chk_pin_low: assert property (rdy_busy_o == 1'b0)
		else $error("ready pin value not low");
	chk_erase_busy: assert property (
		array_erase_o |-> rdy_busy_oe_o && !array_we_o)
		else $error("erase pulse outside busy");
	chk_erase_pulse: assert property (array_erase_o |=> !array_erase_o)
		else $error("erase pulse too long");
	chk_we_busy: assert property (array_we_o |-> rdy_busy_oe_o)
		else $error("byte write outside busy");
	chk_we_first: assert property (
		$rose(array_we_o) |-> array_byte_o == 10'h000)
		else $error("stream not starting at byte zero");
	chk_we_order: assert property (array_we_o ##1 array_we_o |->
		array_byte_o == $past(array_byte_o) + 10'h001)
		else $error("stream bytes out of order");
	chk_busy_launch: assert property (
		$rose(rdy_busy_oe_o) |-> cs_n_i && dev_rst_n_i)
		else $error("busy without select rise");
	chk_dev_abort: assert property (
		!dev_rst_n_i [*4] |-> !rdy_busy_oe_o && !array_we_o)
		else $error("busy held during device reset");
	chk_block_page: assert property (array_block_o && rdy_busy_oe_o |->
		array_page_o[2:0] == 3'h0)
		else $error("block erase low page bits set");
	chk_oe_select: assert property (so_oe_o |-> !cs_n_i)
		else $error("output driven while deselected");
	chk_busy_bound: assert property (bcnt_reg <= EP_CYC + 1)
		else $error("busy too long");
endmodule // sfp_flash_seq_asserts

/* File: test/sfp_host_model.sv */
// Purpose: serial master driving select, clock and data in
// Assumes: clock idles low; data taken at rise, output moves at fall
// Notes: data line shows the inverse of its last bit when released
`timescale 1ns/1ps
module sfp_host_model (
	input wire logic so_i,
	output logic sck_o,
	output logic cs_n_o,
	output logic si_o
);
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	task automatic shift(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			si_o = v[i];
			#32 sck_o = 1'b1;
			#32 sck_o = 1'b0;
		end
		si_o = ~si_o;
	endtask
	task automatic open(input logic [7:0] op);
		#7 cs_n_o = 1'b0;
		#64 shift({24'h0, op}, 8);
	endtask
	task automatic start(input logic [7:0] op, input logic [23:0] adr);
		open(op);
		shift({8'h0, adr}, 24);
	endtask
	// Sampled at each rise, half a period after the output moved
	task automatic status(output logic [7:0] v);
		for (int i = 7; i >= 0; i--) begin
			#32 sck_o = 1'b1;
			v[i] = so_i;
			#32 sck_o = 1'b0;
		end
	endtask
	task automatic stop();
		#32 cs_n_o = 1'b1;
		#250;
	endtask
endmodule // sfp_host_model

/* File: test/sfp_flash_seq_bench.sv */
// Purpose: self-checking bench of the flash sequencer
// Assumes: shortened self-timed counts
// Notes: array side is watched, not modelled
`timescale 1ns/1ps
module sfp_flash_seq_bench;
	import sfp_pkg::*;
	localparam int XF_C = 40;
	localparam int PE_C = 50;
	localparam int P_C = 600;
	localparam int EP_C = 700;
	localparam int BE_C = 80;
	localparam logic [2:0] DENS = 3'h5; // Arbitrary value
	logic clk_i, nrst_i, sck_i, cs_n_i, si_i, so_o, so_oe_o, so_w;
	logic rdy_busy_o, rdy_busy_oe_o, dev_rst_n_i, array_mismatch_i;
	logic array_erase_o, array_block_o, array_we_o, cmp, blk_seen, so_last;
	logic [12:0] array_page_o, pg, pg_seen;
	logic [9:0] array_byte_o;
	logic [7:0] array_data_o;
	logic [7:0] seen [0:527];
	logic [7:0] bm [0:1][0:527];
	bit bv [0:1][0:527];
	logic [31:0] rs = 32'h3986;
	logic [31:0] rv;
	int n_mismatch, comparisons, n_er, n_we, n_busy, cyc;
	logic [7:0] ops [14] = '{8'h83, 8'h86, 8'h81, 8'h88, 8'h50, 8'h89,
		8'h82, 8'h85, 8'h58, 8'h59, 8'h53, 8'h55, 8'h60, 8'h61};
	// Released line shows the inverse of its last bit, so stale never matches
	always @(so_o or so_oe_o) begin
		if (so_oe_o === 1'b1) so_last = so_o;
	end
	assign so_w = so_oe_o ? so_o : ~so_last;
	sfp_flash_seq #(.XFER_CYC(XF_C), .PE_CYC(PE_C), .P_CYC(P_C),
		.EP_CYC(EP_C), .BE_CYC(BE_C), .DENSITY_CODE(DENS))
		sfp_flash_seq_inst (.clk_i, .nrst_i, .sck_i, .cs_n_i, .si_i, .so_o,
		.so_oe_o, .rdy_busy_o, .rdy_busy_oe_o, .dev_rst_n_i,
		.array_mismatch_i, .array_erase_o, .array_block_o, .array_page_o,
		.array_we_o, .array_byte_o, .array_data_o);
	sfp_host_model host_inst (.so_i(so_w), .sck_o(sck_i), .cs_n_o(cs_n_i),
		.si_o(si_i));
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	always @(negedge clk_i) begin
		if (rdy_busy_oe_o === 1'b1) begin
			n_busy++;
			pg_seen = array_page_o;
			blk_seen = array_block_o;
		end
		if (array_erase_o === 1'b1) n_er++;
		if (array_we_o === 1'b1) begin
			n_we++;
			seen[array_byte_o] = array_data_o;
		end
	end
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 50000) begin
			n_mismatch++;
			complete_run();
		end
	end
	function automatic logic [31:0] rnd();
		rs ^= rs << 13;
		rs ^= rs >> 17;
		rs ^= rs << 5;
		return rs;
	endfunction
	function automatic int exp_busy(input logic [7:0] op);
		case (op)
			8'h88, 8'h89: return P_C;
			8'h81: return PE_C;
			8'h50: return BE_C;
			8'h53, 8'h55, 8'h60, 8'h61: return XF_C;
			default: return EP_C;
		endcase
	endfunction
	task automatic check(input logic [31:0] v, input logic [31:0] e);
		comparisons++;
		if (v !== e) begin
			n_mismatch++;
			$display("[ERR] %0t seen %0h expected %0h", $time, v, e);
		end
	endtask
	task automatic complete_run();
		if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic wbytes(input logic b, input logic [9:0] s, input int n);
		logic [9:0] a;
		for (int k = 0; k < n; k++) begin
			rv = rnd();
			a = 10'((s + k) % 528);
			host_inst.shift(rv, 8);
			bm[b][a] = rv[7:0];
			bv[b][a] = 1'b1;
		end
	endtask
	task automatic stat_chk();
		logic [7:0] st;
		host_inst.open(8'h57);
		repeat (2) begin
			host_inst.status(st);
			check(st[7:3], {1'b1, cmp, DENS});
		end
		host_inst.stop();
	endtask
	task automatic run_op(input logic [7:0] op);
		logic [23:0] adr;
		logic b;
		int e;
		rv = rnd();
		b = op inside {8'h86, 8'h89, 8'h85, 8'h59};
		e = exp_busy(op);
		adr = {1'b0, pg, rv[9:0]};
		if (op == 8'h50) adr = {1'b0, pg[12:3], rv[12:0]};
		if (op inside {8'h82, 8'h85}) adr[9:0] = 10'h20E;
		@(posedge clk_i);
		array_mismatch_i <= rv[31];
		if (op inside {8'h60, 8'h61}) cmp = rv[31];
		n_er = 0;
		n_we = 0;
		n_busy = 0;
		host_inst.start(op, adr);
		if (op inside {8'h82, 8'h85}) wbytes(b, 10'h20E, 3);
		host_inst.stop();
		if (e > 200) begin
			host_inst.open(8'h57);
			// Output moves on the last fall; look once it has settled
			#20;
			check(so_w, 1'b0);
		end
		for (int t = 0; t < 2000 && rdy_busy_oe_o !== 1'b0; t++)
			@(posedge clk_i);
		#30;
		if (e > 200) begin
			check(so_w, 1'b1);
			host_inst.stop();
		end
		check(n_busy inside {[e - 2:e + 1]}, 1'b1);
		check(n_er, (op inside {8'h88, 8'h89, 8'h53, 8'h55, 8'h60, 8'h61})
			? 0 : 1);
		check(n_we, (op inside {8'h81, 8'h50, 8'h53, 8'h55, 8'h60, 8'h61})
			? 0 : 528);
		check(pg_seen, (op == 8'h50) ? {pg[12:3], 3'h0} : pg);
		check(blk_seen, op == 8'h50);
		for (int i = 0; i < 528; i++) begin
			if (n_we == 528 && bv[b][i])
				check(seen[i], bm[b][i]);
		end
		stat_chk();
	endtask
	initial begin
		nrst_i = 1'b0;
		dev_rst_n_i = 1'b1;
		array_mismatch_i = 1'b0;
		cmp = 1'b0;
		repeat (3) @(posedge clk_i);
		nrst_i <= 1'b1;
		repeat (4) @(posedge clk_i);
		stat_chk();
		host_inst.start(8'h84, 24'h00020E);
		wbytes(0, 10'h20E, 4);
		host_inst.stop();
		host_inst.start(8'h87, 24'h000000);
		wbytes(1, 10'h000, 3);
		host_inst.stop();
		foreach (ops[i]) begin
			rv = rnd();
			// Program-only reuses the page or block just erased
			if (!(ops[i] inside {8'h88, 8'h89})) pg = rv[12:0];
			run_op(ops[i]);
		end
		host_inst.start(8'h83, 24'h0);
		host_inst.stop();
		repeat (20) @(posedge clk_i);
		check(rdy_busy_oe_o, 1'b1);
		dev_rst_n_i <= 1'b0;
		repeat (6) @(posedge clk_i);
		check(rdy_busy_oe_o, 1'b0);
		dev_rst_n_i <= 1'b1;
		repeat (5) @(posedge clk_i);
		stat_chk();
		complete_run();
	end
endmodule // sfp_flash_seq_bench
bind sfp_flash_seq sfp_flash_seq_asserts #(.EP_CYC(EP_CYC))
	sfp_flash_seq_asserts_inst (.clk_i, .nrst_i, .cs_n_i, .dev_rst_n_i,
	.so_oe_o, .rdy_busy_o, .rdy_busy_oe_o, .array_erase_o, .array_block_o,
	.array_page_o, .array_we_o, .array_byte_o);
